// ===== verilog/usc_serial_control.sv
// Serial port control: registers, frame build, receiver, wake-up, idle
// and break detection, pin routing and the interrupt request.
// Assumes a byte register port with one-cycle strobes and read data one
// cycle later; serial pins are synchronous to mclk_in.
// Summary of operation
// R01: Loopback bit routes transmitter to receiver internally; clear gives two-wire operation.
// R02: Stop-length bit selects two stop bits when set, one when clear.
// R03: In loopback, one-wire bit uses the transmit pin; clear leaves it unused.
// R04: Frame-length bit selects nine bits, else eight data bits.
// R05: Parity enabled generates and checks parity; odd when select set, even otherwise.
// R06: Enable bit runs the port; clearing it stops and resets the serial function.
// R07: Four enable bits mask the four interrupt sources individually.
// R08: Transmitter and receiver each work only while their own enable is set.
// R09: Standby bit holds the receiver waiting for its wake condition.
// R10: Software writes 1 then 0 to send one break.
// R11: Ninth received bit is readable; ninth transmitted bit is software written.
// R12: In one-wire mode the direction bit picks pin output or receiver input.
// R13: Polarity bits invert transmitted and received data independently.
// R14: Idle seen in standby sets the idle flag only when reporting is enabled.
// R15: Idle-type set starts idle counting after the stop bit.
// R16: Idle-type clear counts from the start bit, ten bits plus extras.
// R17: Wake-mode bit selects address-mark or idle-line wake-up.
// R18: Break lasts thirteen or ten bit times, plus one for nine bits, two stops.
// R19: Break detected after eleven low bit times, plus extras.
// R20: Address-mark wake clears standby when the highest received bit is 1.
// R21: Idle-line wake clears standby; flags resume from the next character.
// R22: One interrupt request is the OR of all enabled flags.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module usc_serial_control #(
  parameter int unsigned BIT_CYCLES = usc_pkg::BIT_CYCLES_DEF
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output var  logic [7:0] rdata_out,
  output var  logic       txd_out,
  output var  logic       txd_oe_out,
  input  wire logic       txd_in,
  input  wire logic       rxd_in,
  output var  logic       irq_out
);

  localparam logic [15:0] HALF_CYCLES = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] BIT_LAST    = 16'(BIT_CYCLES - 1);

  typedef struct packed {
    logic [7:0]             frame;
    logic [7:0]             ctrl;
    logic [7:0]             pin;
    logic [1:0]             brk_cfg;
    logic                   brk_if;
    logic                   edge_if;
    logic                   brk_pend;
    logic                   tx_start;
    logic [15:0]            tx_pat;
    logic [3:0]             tx_n;
    logic [7:0]             tx_buf;
    logic                   tx_full;
    logic [7:0]             rx_data;
    logic                   rx_full;
    logic                   idle_f;
    logic                   ovr;
    logic                   ferr;
    logic                   perr;
    logic [7:0]             rdata;
    usc_pkg::usc_rx_state_t rx_state;
    logic [15:0]            rx_timer;
    logic [3:0]             rx_idx;
    logic [9:0]             rx_bits;
    logic                   line_prev;
    logic [15:0]            hi_run;
    logic [15:0]            lo_run;
    logic                   idle_armed;
  } usc_state_t;

  localparam usc_state_t RESET_STATE = '{
    frame: usc_pkg::RST_FRAME, ctrl: usc_pkg::RST_CTRL, pin: usc_pkg::RST_PIN,
    brk_cfg: usc_pkg::RST_BREAK, tx_pat: 16'hFFFF, rx_state: usc_pkg::RX_IDLE,
    line_prev: 1'b1, default: '0};

  usc_state_t s_reg;
  usc_state_t s_next;
  usc_tx_if   tif ();

  usc_tx_engine #(.BIT_CYCLES(BIT_CYCLES)) u_engine (
    .mclk_in (mclk_in),
    .rst_in  (rst_in || !s_reg.frame[usc_pkg::F_ENABLE]), // R06
    .tx      (tif.engine)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic        enabled;
  logic        loop_on;
  logic        one_wire;
  logic        nine;
  logic [1:0]  extra;
  logic [3:0]  nd;
  logic [3:0]  brk_len;
  logic [15:0] idle_cyc;
  logic [15:0] brk_cyc;
  logic        tx_pin_val;
  logic        rx_line;
  logic        tx_done_lvl;
  logic [7:0]  read_val;

  assign enabled  = s_reg.frame[usc_pkg::F_ENABLE];
  assign loop_on  = s_reg.frame[usc_pkg::F_LOOP];
  assign one_wire = s_reg.frame[usc_pkg::F_ONEWIRE];
  assign nine     = s_reg.frame[usc_pkg::F_NINE];
  assign extra    = {1'b0, nine} + {1'b0, s_reg.frame[usc_pkg::F_STOP2]};
  assign nd       = nine ? 4'd9 : 4'd8; // R04
  assign brk_len  = (s_reg.brk_cfg[usc_pkg::B_LONG] ? usc_pkg::BREAK_LONG_BITS
                    : usc_pkg::BREAK_SHORT_BITS) + {2'b00, extra}; // R18
  assign idle_cyc = 16'(({2'b00, usc_pkg::IDLE_BITS} + {4'h0, extra}) * BIT_CYCLES); // R16
  assign brk_cyc  = 16'(({2'b00, usc_pkg::BREAK_DETECT_BITS} + {4'h0, extra}) * BIT_CYCLES);

  // Pin routing; inversion sits at the pin so loopback sees pin polarity
  assign tx_pin_val = tif.line ^ s_reg.pin[usc_pkg::P_TXINV]; // R13
  assign txd_out    = tx_pin_val;
  assign txd_oe_out = enabled && (!loop_on || (one_wire && s_reg.pin[usc_pkg::P_DIR])); // R01 R03 R12
  assign rx_line    = (!loop_on ? rxd_in
                      : (one_wire && !s_reg.pin[usc_pkg::P_DIR]) ? txd_in
                      : tx_pin_val) ^ s_reg.pin[usc_pkg::P_RXINV]; // R01 R03 R12 R13

  assign tx_done_lvl = !s_reg.tx_full && !tif.busy && !s_reg.tx_start && !s_reg.brk_pend;
  assign irq_out = enabled && |{s_reg.ctrl[usc_pkg::C_IE_TXE] && !s_reg.tx_full,
                                s_reg.ctrl[usc_pkg::C_IE_TXD] && tx_done_lvl,
                                s_reg.ctrl[usc_pkg::C_IE_RXF] && s_reg.rx_full,
                                s_reg.ctrl[usc_pkg::C_IE_IDLE] && s_reg.idle_f}; // R07 R22
  assign tif.start   = s_reg.tx_start;
  assign tif.pattern = s_reg.tx_pat;
  assign tif.nbits   = s_reg.tx_n;
  assign rdata_out   = s_reg.rdata;

  always_comb begin
    read_val = 8'h00;
    if (hit(addr_in, usc_pkg::OFF_FRAME)) begin
      read_val = s_reg.frame;
    end else if (hit(addr_in, usc_pkg::OFF_CTRL)) begin
      read_val = s_reg.ctrl;
    end else if (hit(addr_in, usc_pkg::OFF_PIN)) begin
      read_val = s_reg.pin; // R11
    end else if (hit(addr_in, usc_pkg::OFF_BREAK)) begin
      read_val = {s_reg.brk_if, s_reg.edge_if, s_reg.rx_state != usc_pkg::RX_IDLE,
                  3'b000, s_reg.brk_cfg};
    end else if (hit(addr_in, usc_pkg::OFF_STATUS)) begin
      read_val = {!s_reg.tx_full, tx_done_lvl, s_reg.rx_full, s_reg.idle_f,
                  s_reg.ovr, 1'b0, s_reg.ferr, s_reg.perr};
    end else if (hit(addr_in, usc_pkg::OFF_DATA)) begin
      read_val = s_reg.rx_data;
    end
  end

  always_comb begin
    logic       rx_en;
    logic       standby;
    logic       wake_addr;
    logic       frame_done;
    logic       top;
    logic       par_bad;
    logic       ev_full;
    logic       ev_ovr;
    logic       ev_ferr;
    logic       ev_perr;
    logic       ev_idle;
    logic [9:0] got;
    rx_en      = s_reg.ctrl[usc_pkg::C_RX_EN];
    standby    = s_reg.ctrl[usc_pkg::C_STANDBY];
    wake_addr  = s_reg.pin[usc_pkg::P_WAKE_ADDR];
    frame_done = 1'b0;
    ev_full    = 1'b0;
    ev_ovr     = 1'b0;
    ev_ferr    = 1'b0;
    ev_perr    = 1'b0;
    ev_idle    = 1'b0;
    got        = s_reg.rx_bits;
    top        = 1'b0;
    par_bad    = 1'b0;
    s_next     = s_reg;
    s_next.tx_start = 1'b0;
    if (rst_in || !enabled) begin
      s_next = RESET_STATE; // R06
      s_next.frame = rst_in ? usc_pkg::RST_FRAME : s_reg.frame;
      if (!rst_in && wr_in && hit(addr_in, usc_pkg::OFF_FRAME)) begin
        s_next.frame = wdata_in & usc_pkg::FRAME_WMASK;
      end
    end else begin
      // Line run lengths feed idle and break detection
      s_next.line_prev = rx_line;
      if (rx_line) begin
        s_next.lo_run = 16'h0000;
        s_next.hi_run = (s_reg.hi_run == 16'hFFFF) ? s_reg.hi_run : s_reg.hi_run + 16'h0001;
      end else begin
        s_next.hi_run = 16'h0000;
        s_next.lo_run = (s_reg.lo_run == 16'hFFFF) ? s_reg.lo_run : s_reg.lo_run + 16'h0001;
      end
      if (rx_en && s_reg.line_prev && !rx_line) begin
        s_next.edge_if = 1'b1;
      end
      if (rx_en && s_reg.brk_cfg[usc_pkg::B_DETECT] && s_reg.lo_run == brk_cyc) begin
        s_next.brk_if = 1'b1; // R19
      end

      case (s_reg.rx_state)
        usc_pkg::RX_IDLE: begin
          if (rx_en && s_reg.line_prev && !rx_line) begin // R08
            s_next.rx_state = usc_pkg::RX_START;
            s_next.rx_timer = 16'h0000;
          end
        end
        usc_pkg::RX_START: begin
          if (!rx_en) begin
            s_next.rx_state = usc_pkg::RX_IDLE;
          end else if (s_reg.rx_timer == HALF_CYCLES - 16'h0001) begin
            // A start bit that is gone by mid-bit was noise
            s_next.rx_state = rx_line ? usc_pkg::RX_IDLE : usc_pkg::RX_BITS;
            s_next.rx_timer = 16'h0000;
            s_next.rx_idx   = 4'h0;
          end else begin
            s_next.rx_timer = s_reg.rx_timer + 16'h0001;
          end
        end
        usc_pkg::RX_BITS: begin
          if (!rx_en) begin
            s_next.rx_state = usc_pkg::RX_IDLE;
          end else if (s_reg.rx_timer == BIT_LAST) begin
            s_next.rx_timer = 16'h0000;
            s_next.rx_bits[s_reg.rx_idx] = rx_line;
            s_next.rx_idx = s_reg.rx_idx + 4'h1;
            if (s_reg.rx_idx == nd) begin
              s_next.rx_state = usc_pkg::RX_IDLE;
              frame_done = 1'b1;
            end
          end else begin
            s_next.rx_timer = s_reg.rx_timer + 16'h0001;
          end
        end
        default: s_next.rx_state = usc_pkg::RX_IDLE;
      endcase

      got = s_next.rx_bits;
      top = nine ? got[8] : got[7];
      par_bad = (nine ? ^got[8:0] : ^got[7:0]) ^ s_reg.frame[usc_pkg::F_PAR_ODD];
      if (frame_done) begin
        s_next.idle_armed = 1'b1;
        if (s_reg.pin[usc_pkg::P_IDLE_TYPE]) begin
          s_next.hi_run = 16'h0000; // R15
        end
        if (standby && wake_addr && top) begin
          s_next.ctrl[usc_pkg::C_STANDBY] = 1'b0; // R17 R20
        end
        if (!standby || (wake_addr && top)) begin // R09
          if (s_reg.rx_full) begin
            ev_ovr = 1'b1;
          end else begin
            s_next.rx_data = got[7:0];
            if (nine) begin
              s_next.pin[usc_pkg::P_RX9] = got[8]; // R11
            end
            ev_full = 1'b1;
          end
          ev_ferr = !got[nd];
          ev_perr = s_reg.frame[usc_pkg::F_PAR_EN] && par_bad; // R05
        end
      end
      if (rx_en && s_reg.idle_armed && s_reg.hi_run == idle_cyc) begin // R16
        s_next.idle_armed = 1'b0;
        if (!standby) begin
          ev_idle = 1'b1;
        end else begin
          ev_idle = s_reg.pin[usc_pkg::P_STBY_IDLE]; // R14
          if (!wake_addr) begin
            s_next.ctrl[usc_pkg::C_STANDBY] = 1'b0; // R17 R21
          end
        end
      end

      // Transmit launch; a pending break goes ahead of buffered data
      if (s_reg.ctrl[usc_pkg::C_TX_EN] && !tif.busy && !s_reg.tx_start) begin // R08
        if (s_reg.brk_pend) begin
          s_next.tx_pat   = 16'hFFFF << brk_len; // R18
          s_next.tx_n     = brk_len;
          s_next.brk_pend = 1'b0;
          s_next.tx_start = 1'b1;
        end else if (s_reg.tx_full) begin
          s_next.tx_pat = {4'hF, 2'b11,
                           nine ? (s_reg.frame[usc_pkg::F_PAR_EN]
                                   ? ^s_reg.tx_buf ^ s_reg.frame[usc_pkg::F_PAR_ODD]
                                   : s_reg.pin[usc_pkg::P_TX9])
                                : 1'b1, // R04 R05 R11
                           (!nine && s_reg.frame[usc_pkg::F_PAR_EN])
                             ? ^s_reg.tx_buf[6:0] ^ s_reg.frame[usc_pkg::F_PAR_ODD]
                             : s_reg.tx_buf[7],
                           s_reg.tx_buf[6:0], 1'b0};
          s_next.tx_n = 4'h1 + nd + (s_reg.frame[usc_pkg::F_STOP2] ? 4'h2 : 4'h1); // R02
          s_next.tx_full  = 1'b0;
          s_next.tx_start = 1'b1;
        end
      end

      if (wr_in) begin
        if (hit(addr_in, usc_pkg::OFF_FRAME)) begin
          s_next.frame = wdata_in & usc_pkg::FRAME_WMASK;
        end else if (hit(addr_in, usc_pkg::OFF_CTRL)) begin
          if (s_reg.ctrl[usc_pkg::C_BRK] && !wdata_in[usc_pkg::C_BRK]) begin
            s_next.brk_pend = 1'b1; // R10
          end
          s_next.ctrl = wdata_in;
        end else if (hit(addr_in, usc_pkg::OFF_PIN)) begin
          s_next.pin[6:0] = wdata_in[6:0];
        end else if (hit(addr_in, usc_pkg::OFF_BREAK)) begin
          s_next.brk_cfg = wdata_in[1:0];
          if (wdata_in[usc_pkg::B_BRK_IF]) begin
            s_next.brk_if = 1'b0;
          end
          if (wdata_in[usc_pkg::B_EDGE_IF]) begin
            s_next.edge_if = 1'b0;
          end
        end else if (hit(addr_in, usc_pkg::OFF_DATA)) begin
          s_next.tx_buf  = wdata_in;
          s_next.tx_full = 1'b1;
        end else if (hit(addr_in, usc_pkg::OFF_CLEAR)) begin
          s_next.rx_full = s_reg.rx_full && !wdata_in[usc_pkg::S_RXF];
          s_next.idle_f  = s_reg.idle_f && !wdata_in[usc_pkg::S_IDLE];
          s_next.ovr     = s_reg.ovr && !wdata_in[usc_pkg::S_OVR];
          s_next.ferr    = s_reg.ferr && !wdata_in[usc_pkg::S_FERR];
          s_next.perr    = s_reg.perr && !wdata_in[usc_pkg::S_PERR];
        end
      end
      // Hardware events win over a same-cycle software clear
      if (rx_en && s_reg.line_prev && !rx_line) begin
        s_next.edge_if = 1'b1;
      end
      if (rx_en && s_reg.brk_cfg[usc_pkg::B_DETECT] && s_reg.lo_run == brk_cyc) begin
        s_next.brk_if = 1'b1;
      end
      s_next.rx_full = s_next.rx_full || ev_full;
      s_next.ovr     = s_next.ovr || ev_ovr;
      s_next.ferr    = s_next.ferr || ev_ferr;
      s_next.perr    = s_next.perr || ev_perr;
      s_next.idle_f  = s_next.idle_f || ev_idle;
    end
    s_next.rdata = (!rst_in && rd_in) ? read_val : 8'h00;
  end

  always_ff @(posedge mclk_in) begin
    s_reg <= s_next;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence brk_arm_s;
    enabled && wr_in && hit(addr_in, usc_pkg::OFF_CTRL) && s_reg.ctrl[usc_pkg::C_BRK]
      && !wdata_in[usc_pkg::C_BRK];
  endsequence

  chk_two_wire_out: assert property (enabled && !loop_on |-> txd_oe_out) // R01
    else $error("two-wire mode must drive the transmit pin");
  chk_loop_internal: assert property (loop_on && !one_wire |-> !txd_oe_out) // R03
    else $error("internal loopback must leave the transmit pin undriven");
  chk_one_wire_dir: assert property (enabled && loop_on && one_wire
    |-> txd_oe_out == s_reg.pin[usc_pkg::P_DIR]) // R12
    else $error("one-wire pin direction does not follow the direction bit");
  chk_txd_invert: assert property (!tif.busy |-> txd_out == !s_reg.pin[usc_pkg::P_TXINV]) // R13
    else $error("idle transmit pin not at mark after polarity");
  chk_disable_clears: assert property (!enabled |=> s_reg.ctrl == 8'h00 && !s_reg.rx_full
    && !tif.busy) // R06
    else $error("disable did not reset the serial function");
  chk_break_request: assert property (brk_arm_s |=> s_reg.brk_pend ##1 1'b1) // R10
    else $error("break not requested after writing 1 then 0");
  chk_rx_closed: assert property (enabled && !s_reg.ctrl[usc_pkg::C_RX_EN]
    |=> s_reg.rx_state == usc_pkg::RX_IDLE) // R08
    else $error("receiver ran while closed");
  chk_tx_closed: assert property (!s_reg.ctrl[usc_pkg::C_TX_EN] |=> !tif.start) // R08
    else $error("transmitter started while closed");
  chk_irq_masked: assert property (s_reg.ctrl[7:4] == 4'h0 |-> !irq_out) // R07
    else $error("interrupt raised with every source masked");
  chk_irq_rxfull: assert property (enabled && s_reg.ctrl[usc_pkg::C_IE_RXF] && s_reg.rx_full
    |-> irq_out) // R22
    else $error("enabled receive-full flag did not raise the request");

endmodule : usc_serial_control
`default_nettype wire

// ===== include/usc_pkg.sv
// Shared constants for the serial port control block: register offsets,
// field positions, reset values, idle and break lengths, state types.
// Assumes byte-wide register access over a plain strobe port.
package usc_pkg;

  // Register offsets
  localparam logic [7:0] OFF_FRAME  = 8'hC4;
  localparam logic [7:0] OFF_CTRL   = 8'hC5;
  localparam logic [7:0] OFF_PIN    = 8'hC6;
  localparam logic [7:0] OFF_BREAK  = 8'hC7;
  localparam logic [7:0] OFF_STATUS = 8'hC8;
  localparam logic [7:0] OFF_DATA   = 8'hC9;
  localparam logic [7:0] OFF_CLEAR  = 8'hD8;

  // Reset values and the frame write mask
  localparam logic [7:0] RST_FRAME = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_PIN   = 8'h00;
  localparam logic [1:0] RST_BREAK = 2'h0;
  localparam logic [7:0] FRAME_WMASK = 8'hFD;

  // frame_format_control fields
  localparam int F_LOOP    = 7;
  localparam int F_STOP2   = 6;
  localparam int F_ONEWIRE = 5;
  localparam int F_NINE    = 4;
  localparam int F_PAR_EN  = 3;
  localparam int F_PAR_ODD = 2;
  localparam int F_ENABLE  = 0;

  // enable_interrupt_control fields
  localparam int C_IE_TXE  = 7;
  localparam int C_IE_TXD  = 6;
  localparam int C_IE_RXF  = 5;
  localparam int C_IE_IDLE = 4;
  localparam int C_TX_EN   = 3;
  localparam int C_RX_EN   = 2;
  localparam int C_STANDBY = 1;
  localparam int C_BRK     = 0;

  // pin_wake_control fields
  localparam int P_RX9       = 7;
  localparam int P_TX9       = 6;
  localparam int P_DIR       = 5;
  localparam int P_TXINV     = 4;
  localparam int P_RXINV     = 3;
  localparam int P_STBY_IDLE = 2;
  localparam int P_IDLE_TYPE = 1;
  localparam int P_WAKE_ADDR = 0;

  // break_sync_control fields
  localparam int B_BRK_IF  = 7;
  localparam int B_EDGE_IF = 6;
  localparam int B_RX_ACT  = 5;
  localparam int B_LONG    = 1;
  localparam int B_DETECT  = 0;

  // Status fields (status read, clear write)
  localparam int S_TXE  = 7;
  localparam int S_TXD  = 6;
  localparam int S_RXF  = 5;
  localparam int S_IDLE = 4;
  localparam int S_OVR  = 3;
  localparam int S_FERR = 1;
  localparam int S_PERR = 0;

  // Lengths in bit times, and the default mclk cycles per bit time
  localparam logic [3:0] BREAK_SHORT_BITS  = 4'd10;
  localparam logic [3:0] BREAK_LONG_BITS   = 4'd13;
  localparam logic [3:0] BREAK_DETECT_BITS = 4'd11;
  localparam logic [3:0] IDLE_BITS         = 4'd10;
  localparam int unsigned BIT_CYCLES_DEF   = 16;

  typedef enum logic [1:0] {
    TXE_IDLE = 2'b01,
    TXE_SEND = 2'b10
  } usc_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_BITS  = 3'b100
  } usc_rx_state_t;

endpackage : usc_pkg

// ===== include/usc_tx_if.sv
// Connection between the control logic and the serial shift engine.
// Assumes start is a one-cycle pulse taken only while busy is low.
`timescale 1ns/1ps
`default_nettype none
interface usc_tx_if;
  logic        start;
  logic [15:0] pattern;
  logic [3:0]  nbits;
  logic        busy;
  logic        line;

  modport ctrl   (output start, pattern, nbits, input busy, line);
  modport engine (input start, pattern, nbits, output busy, line);
endinterface : usc_tx_if
`default_nettype wire

// ===== verilog/usc_tx_engine.sv
// Serial shift engine: sends a prepared bit pattern LSB first, one bit
// per bit time. Frames and breaks use the same path.
// Assumes the controller holds it in reset while the port is disabled.
`timescale 1ns/1ps
`default_nettype none
module usc_tx_engine #(
  parameter int unsigned BIT_CYCLES = usc_pkg::BIT_CYCLES_DEF
) (
  input  wire logic  mclk_in,
  input  wire logic  rst_in,
  usc_tx_if.engine   tx
);

  typedef struct packed {
    usc_pkg::usc_tx_state_t state;
    logic [15:0]            shift;
    logic [3:0]             cnt;
    logic [15:0]            timer;
  } usc_txe_state_t;

  usc_txe_state_t s_reg;
  usc_txe_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (rst_in) begin
      s_next.state = usc_pkg::TXE_IDLE;
      s_next.shift = 16'hFFFF;
      s_next.cnt   = 4'h0;
      s_next.timer = 16'h0000;
    end else begin
      case (s_reg.state)
        usc_pkg::TXE_IDLE: begin
          if (tx.start) begin
            s_next.state = usc_pkg::TXE_SEND;
            s_next.shift = tx.pattern;
            s_next.cnt   = tx.nbits;
            s_next.timer = 16'h0000;
          end
        end
        usc_pkg::TXE_SEND: begin
          if (s_reg.timer == 16'(BIT_CYCLES - 1)) begin
            s_next.timer = 16'h0000;
            // Fill with mark so the line rests high after the last bit
            s_next.shift = {1'b1, s_reg.shift[15:1]};
            s_next.cnt   = s_reg.cnt - 4'h1;
            if (s_reg.cnt == 4'h1) begin
              s_next.state = usc_pkg::TXE_IDLE;
            end
          end else begin
            s_next.timer = s_reg.timer + 16'h0001;
          end
        end
        default: s_next.state = usc_pkg::TXE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    s_reg <= s_next;
  end

  assign tx.line = s_reg.shift[0];
  assign tx.busy = (s_reg.state == usc_pkg::TXE_SEND);

  sequence load_s;
    tx.start && !tx.busy && (tx.nbits != 4'h0);
  endsequence

  chk_send_starts: assert property (@(posedge mclk_in) disable iff (rst_in) // R02
    load_s |=> tx.busy && (tx.line == $past(tx.pattern[0])))
    else $error("engine did not begin sending the loaded pattern");

  chk_idle_mark: assert property (@(posedge mclk_in) disable iff (rst_in) // R02
    !tx.busy && $past(tx.busy) |-> tx.line)
    else $error("line not at mark after the last stop bit");

endmodule : usc_tx_engine
`default_nettype wire

// ===== test/usc_remote_node.sv
// Remote serial node: drives the receive pin with 8N1 frames, LSB first.
// Assumes BC mclk cycles per bit time; the line idles high (mark).
`timescale 1ns/1ps
`default_nettype none
module usc_remote_node #(
  parameter int BC = 4
) (
  input  wire logic mclk_in,
  output var  logic rxd_out
);
  initial rxd_out = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // Start on a clock edge so every bit lasts exactly BC cycles
    @(posedge mclk_in);
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BC) @(posedge mclk_in);
    end
  endtask : send
endmodule : usc_remote_node
`default_nettype wire

// ===== test/usc_serial_control_tb.sv
// Bench for the serial port control block: registers, frames, break, pins.
// Assumes the remote node model drives the receive pin.
`timescale 1ns/1ps
`default_nettype none
module usc_serial_control_tb;
  localparam int BC = 4;
  logic       mclk_in  = 1'b0;
  logic       rst_in   = 1'b1;
  logic       wr_in    = 1'b0;
  logic       rd_in    = 1'b0;
  logic [7:0] addr_in  = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out, v;
  logic       txd_out, txd_oe_out, rxd, irq_out;
  // Released pin is pulled up
  wire        pin = txd_oe_out ? txd_out : 1'b1;
  int         fail_count = 0;
  int         cmp_count = 0;
  always #10 mclk_in = ~mclk_in;
  usc_remote_node #(.BC(BC)) u_usc_remote_node (.mclk_in(mclk_in), .rxd_out(rxd));
  usc_serial_control #(.BIT_CYCLES(BC)) u_usc_serial_control (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .txd_out(txd_out),
    .txd_oe_out(txd_oe_out), .txd_in(pin), .rxd_in(rxd), .irq_out(irq_out));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  task automatic wait_low();
    int t;
    for (t = 0; t < 400 && txd_out !== 1'b0; t++) begin
      @(posedge mclk_in);
      #1;
    end
    chk("line low", 16'(t < 400), 16'h1);
    if (t >= 400) end_sim();
  endtask : wait_low
  task automatic frame(input logic [9:0] f);
    wait_low();
    for (int i = 0; i < 10; i++) begin
      repeat (i == 0 ? BC / 2 : BC) @(posedge mclk_in);
      #1 chk("tx bit", txd_out, f[i]);
    end
  endtask : frame
  task automatic brk(input int n);
    int c;
    wait_low();
    for (c = 1; c < 200 && txd_out === 1'b0; c++) begin
      @(posedge mclk_in);
      #1;
    end
    chk("break length", 16'(c - 1), 16'(n));
  endtask : brk
  task automatic t_regs();
    for (int a = 8'hC4; a < 8'hC8; a++) begin
      rd(8'(a));
      chk("reset value", v, 8'h00);
    end
    wr(8'hC5, 8'hFF);
    rd(8'hC5);
    chk("write while off", v, 8'h00);
    rd(8'hC0);
    chk("unmapped", v, 8'h00);
    wr(8'hC4, 8'h01);
    wr(8'hC5, 8'h0C);
    rd(8'hC5);
    chk("control", v, 8'h0C);
    $display("test regs done");
  endtask : t_regs
  task automatic t_frames();
    wr(8'hC9, 8'h55);
    frame(10'h2AA);
    repeat (BC) @(posedge mclk_in);
    wr(8'hC4, 8'h0D);
    wr(8'hC9, 8'h55);
    frame(10'h3AA);
    repeat (BC) @(posedge mclk_in);
    $display("test frames done");
  endtask : t_frames
  task automatic t_break();
    wr(8'hC4, 8'h01);
    wr(8'hC5, 8'h0D);
    wr(8'hC5, 8'h0C);
    brk(10 * BC);
    wr(8'hC4, 8'h11);
    wr(8'hC7, 8'h02);
    wr(8'hC5, 8'h0D);
    wr(8'hC5, 8'h0C);
    brk(14 * BC);
    wr(8'hC7, 8'h00);
    $display("test break done");
  endtask : t_break
  task automatic t_pins();
    wr(8'hC4, 8'h01);
    wr(8'hC6, 8'h10);
    #1 chk("inverted idle", txd_out, 1'b0);
    wr(8'hC6, 8'h00);
    wr(8'hC4, 8'h81);
    #1 chk("loop pin drive", txd_oe_out, 1'b0);
    wr(8'hC9, 8'h3C);
    repeat (12 * BC) @(posedge mclk_in);
    rd(8'hC9);
    chk("loop data", v, 8'h3C);
    wr(8'hC4, 8'hA1);
    #1 chk("one-wire input", txd_oe_out, 1'b0);
    wr(8'hC6, 8'h20);
    #1 chk("one-wire output", txd_oe_out, 1'b1);
    wr(8'hC6, 8'h00);
    wr(8'hC4, 8'h01);
    #1 chk("two-wire drive", txd_oe_out, 1'b1);
    $display("test pins done");
  endtask : t_pins
  task automatic t_rx_irq();
    // The loopback byte is still held; clear it so the next byte is not an overrun
    wr(8'hD8, 8'h20);
    wr(8'hC6, 8'h01);
    wr(8'hC5, 8'h0E);
    u_usc_remote_node.send(8'h25);
    u_usc_remote_node.send(8'hA5);
    repeat (2 * BC) @(posedge mclk_in);
    rd(8'hC5);
    chk("address wake", v, 8'h0C);
    rd(8'hC9);
    chk("rx data", v, 8'hA5);
    wr(8'hC5, 8'h8C);
    #1 chk("irq on", irq_out, 1'b1);
    wr(8'hC5, 8'h0C);
    #1 chk("irq masked", irq_out, 1'b0);
    wr(8'hC4, 8'h00);
    rd(8'hC5);
    chk("disable reset", v, 8'h00);
    $display("test rx irq done");
  endtask : t_rx_irq
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_regs();
    t_frames();
    t_break();
    t_pins();
    t_rx_irq();
    end_sim();
  end
endmodule : usc_serial_control_tb
`default_nettype wire
